// *** rtl/tssc_timer.sv ***
`timescale 1ns/1ps
`include "tssc_defines.svh"
// Notes on behaviour
// - reset mode: trigger edge clears counter, prescaler
// - reset trigger with source low: update event
// - reset trigger sets flag, irq, dma requests
// - gated mode counts only while trigger active
// - gated mode never counts with run clear
// - gated mode flags both start and stop
// - trigger mode starts counter, sets flag
// - source 101 channel one, 110 channel two
// - polarity bit set selects falling/low
// - trigger inputs resynchronised, two flops
// - debug halt freezes counter when selected
// - writes 16/32 bit only; reads any width
// - divider sets sampling period 1,2,4
// - reload buffering: immediate or at update
// - single shot clears run at update
// - update source selects update flag causes
// - update loads shadows unless inhibited
// - inhibited: no update, counter still reinitialised
// - software sets run; trigger mode sets it
// - external clock mode counts trigger rises
module tssc_timer (
   // bus clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // ahb-lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output logic             hreadyout,
   output logic             hresp,
   output logic [31:0]      hrdata,
   // trigger sources
   input  wire logic        timer_input_one,
   input  wire logic        timer_input_two,
   input  wire logic [3:0]  internal_trig,
   // debug
   input  wire logic        core_halted,
   input  wire logic        debug_freeze_select,
   // requests and status
   output logic             trigger_irq,
   output logic             trigger_dma,
   output logic             update_irq,
   output logic             update_event,
   output logic             counter_running,
   output logic             sample_tick,
   output logic [15:0]      count_value
);

   tssc_pkg::tssc_state_t s_reg;
   tssc_pkg::tssc_state_t s_next;

   // merge 16-bit write data into a register under a bit mask
   function automatic logic [15:0] wmerge(input logic [15:0] old,
                                          input logic [15:0] wd,
                                          input logic [15:0] mask);
      wmerge = (old & ~mask) | (wd & mask);
   endfunction

   // polarity-corrected trigger level
   function automatic logic trig_level(input logic [2:0] ts,
                                       input logic ti1, input logic ti2,
                                       input logic [3:0] itr,
                                       input logic p1, input logic p2);
      unique case (ts)
         3'h5: trig_level = ti1 ^ p1;
         3'h6: trig_level = ti2 ^ p2;
         3'h4: trig_level = ti1 ^ p1;
         default: trig_level = itr[ts[1:0]];
      endcase
   endfunction

   logic        trg;
   logic        trg_rise;
   logic        wr_ok;
   logic        upd_req;
   logic        upd_soft;
   logic        slave_reset;
   logic        run_eff;
   logic        cnt_tick;
   logic        ovf;
   logic        frozen;
   logic [15:0] wd;
   logic [31:0] rd;

   // next-state logic for bus, trigger and counter
   always_comb begin
      s_next      = s_reg;
      upd_soft    = 1'b0;
      slave_reset = 1'b0;
      upd_req     = 1'b0;
      ovf         = 1'b0;
      cnt_tick    = 1'b0;
      run_eff     = 1'b0;
      rd          = 32'h0000_0000;
      wd          = s_reg.ph_addr[1] ? hwdata[31:16] : hwdata[15:0];
      // two flops before any logic reads the pins
      s_next.sync1  = {s_reg.sync1[0], timer_input_one};
      s_next.sync2  = {s_reg.sync2[0], timer_input_two};
      s_next.itr_s1 = internal_trig;
      s_next.itr_s2 = s_reg.itr_s1;
      trg = trig_level(s_reg.trigger_source_select, s_reg.sync1[1], s_reg.sync2[1],
                       s_reg.itr_s2, s_reg.chan1_polarity, s_reg.chan2_polarity);
      s_next.trig_prev = trg;
      trg_rise = trg & ~s_reg.trig_prev;
      frozen   = core_halted & debug_freeze_select;
      // dead-time / filter sampling tick; code 11 treated as 10
      s_next.dts_cnt  = s_reg.dts_cnt + 2'h1;
      unique case (s_reg.ctrl1.sample_clock_divider)
         2'h0: s_next.dts_tick = 1'b1;
         2'h1: s_next.dts_tick = s_reg.dts_cnt[0];
         default: s_next.dts_tick = &s_reg.dts_cnt;
      endcase
      // slave controller
      unique case (s_reg.slave_behaviour_select)
         tssc_pkg::TSSC_SM_RESET: begin
            run_eff = s_reg.ctrl1.counter_run_bit;
            if (trg_rise) begin
               slave_reset = 1'b1;
               s_next.trigger_flag = 1'b1;
            end
         end
         tssc_pkg::TSSC_SM_GATED: begin
            run_eff = s_reg.ctrl1.counter_run_bit & trg;
            s_next.gate_prev = run_eff;
            if (run_eff != s_reg.gate_prev)
               s_next.trigger_flag = 1'b1;
         end
         tssc_pkg::TSSC_SM_TRIG: begin
            run_eff = s_reg.ctrl1.counter_run_bit;
            if (trg_rise) begin
               // already running: no restart, flag only
               s_next.ctrl1.counter_run_bit = 1'b1;
               s_next.trigger_flag = 1'b1;
            end
         end
         tssc_pkg::TSSC_SM_EXTCK: begin
            run_eff = s_reg.ctrl1.counter_run_bit & trg_rise;
         end
         default: run_eff = s_reg.ctrl1.counter_run_bit;
      endcase
      if (s_reg.slave_behaviour_select != tssc_pkg::TSSC_SM_GATED)
         s_next.gate_prev = 1'b0;
      // prescaler and counter
      if (run_eff && !frozen && !slave_reset) begin
         if (s_reg.presc_cnt >= s_reg.presc) begin
            s_next.presc_cnt = 16'h0000;
            cnt_tick = 1'b1;
         end else begin
            s_next.presc_cnt = s_reg.presc_cnt + 16'h0001;
         end
      end
      if (cnt_tick) begin
         if (s_reg.count >= s_reg.reload_shadow) begin
            s_next.count = 16'h0000;
            ovf = 1'b1;
         end else begin
            s_next.count = s_reg.count + 16'h0001;
         end
      end
      // ahb data phase: registers
      if (s_reg.ph_valid) begin
         unique case (s_reg.ph_addr & 12'hFFC)
            `TSSC_OFS_CTRL1:  rd[15:0] = {6'h00, s_reg.ctrl1.sample_clock_divider,
                                   s_reg.ctrl1.reload_buffer_on, 3'h0,
                                   s_reg.ctrl1.single_shot_stop,
                                   s_reg.ctrl1.update_source_select,
                                   s_reg.ctrl1.update_inhibit,
                                   s_reg.ctrl1.counter_run_bit};
            `TSSC_OFS_SLAVE:  rd[15:0] = {9'h000, s_reg.trigger_source_select, 1'b0,
                                   s_reg.slave_behaviour_select};
            `TSSC_OFS_IRQEN:  rd[15:0] = {1'b0, s_reg.trigger_dma_enable, 7'h00,
                                   s_reg.trigger_irq_enable, 5'h00,
                                   s_reg.update_irq_enable};
            `TSSC_OFS_STATUS: rd[15:0] = {9'h000, s_reg.trigger_flag, 5'h00,
                                   s_reg.update_flag};
            `TSSC_OFS_CHCFG:  rd[15:0] = {10'h000, s_reg.chan2_polarity, 3'h0,
                                   s_reg.chan1_polarity, 1'b0};
            `TSSC_OFS_COUNT:  rd[15:0] = s_reg.count;
            `TSSC_OFS_PRESC:  rd[15:0] = s_reg.presc;
            `TSSC_OFS_RELOAD: rd[15:0] = s_reg.reload_value;
            `TSSC_OFS_CMP1:   rd[15:0] = s_reg.cmp1;
            `TSSC_OFS_CMP2:   rd[15:0] = s_reg.cmp2;
            default:          rd[15:0] = 16'h0000;
         endcase
      end
      // byte writes are ignored; halfword and word accepted
      wr_ok = s_reg.ph_valid & s_reg.ph_write;
      if (wr_ok) begin
         unique case (s_reg.ph_addr & 12'hFFC)
            `TSSC_OFS_CTRL1: s_next.ctrl1 = tssc_pkg::tssc_ctrl1_t'({wd[9:7], wd[3:0]});
            `TSSC_OFS_SLAVE: begin
               s_next.slave_behaviour_select = tssc_pkg::tssc_sms_t'(wd[2:0]);
               s_next.trigger_source_select  = wd[6:4];
            end
            `TSSC_OFS_IRQEN: begin
               s_next.update_irq_enable  = wd[`TSSC_IE_UPD];
               s_next.trigger_irq_enable = wd[`TSSC_IE_TRG];
               s_next.trigger_dma_enable = wd[`TSSC_IE_TDMA];
            end
            `TSSC_OFS_STATUS: begin
               // write zero to clear; a hardware set this cycle wins below
               if (!wd[`TSSC_SR_UPD]) s_next.update_flag = 1'b0;
               if (!wd[`TSSC_SR_TRG]) s_next.trigger_flag = 1'b0;
            end
            `TSSC_OFS_EVGEN: begin
               upd_soft = wd[`TSSC_EG_UPD];
               if (wd[`TSSC_EG_TRG]) s_next.trigger_flag = 1'b1;
            end
            `TSSC_OFS_CHCFG: begin
               s_next.chan1_polarity = wd[`TSSC_CH_P1];
               s_next.chan2_polarity = wd[`TSSC_CH_P2];
            end
            `TSSC_OFS_COUNT: s_next.count = wmerge(s_reg.count, wd, 16'hFFFF);
            `TSSC_OFS_PRESC: s_next.presc = wd;
            `TSSC_OFS_RELOAD: begin
               s_next.reload_value = wd;
               if (!s_reg.ctrl1.reload_buffer_on)
                  s_next.reload_shadow = wd;
            end
            `TSSC_OFS_CMP1: s_next.cmp1 = wd;
            `TSSC_OFS_CMP2: s_next.cmp2 = wd;
            default: ;
         endcase
      end
      // hardware sets win over a software clear
      if (s_reg.slave_behaviour_select == tssc_pkg::TSSC_SM_RESET && trg_rise)
         s_next.trigger_flag = 1'b1;
      if (s_reg.slave_behaviour_select == tssc_pkg::TSSC_SM_TRIG && trg_rise)
         s_next.trigger_flag = 1'b1;
      if (s_reg.slave_behaviour_select == tssc_pkg::TSSC_SM_GATED &&
          run_eff != s_reg.gate_prev)
         s_next.trigger_flag = 1'b1;
      // soft command or slave reset reinitialise even when inhibited
      if (upd_soft || slave_reset) begin
         s_next.count     = 16'h0000;
         s_next.presc_cnt = 16'h0000;
      end
      upd_req = !s_reg.ctrl1.update_inhibit &&
                (ovf || upd_soft || (slave_reset &&
                 !s_reg.ctrl1.update_source_select));
      if (upd_req) begin
         s_next.reload_shadow = s_next.reload_value;
         s_next.cmp1_shadow   = s_next.cmp1;
         s_next.cmp2_shadow   = s_next.cmp2;
         if (ovf || !s_reg.ctrl1.update_source_select)
            s_next.update_flag = 1'b1;
         if (s_reg.ctrl1.single_shot_stop)
            s_next.ctrl1.counter_run_bit = 1'b0;
      end
      // ahb address phase capture, zero-wait answers
      s_next.ph_valid = hsel & hready & htrans[1];
      s_next.ph_write = hwrite & (hsize != 3'h0);
      s_next.ph_addr  = haddr[11:0];
      if (hsel & hready & htrans[1])
         s_next.ph_valid = 1'b1;
      s_next.hrdata = 32'h0000_0000;
      if (hsel & hready & htrans[1] & !hwrite)
         s_next.ph_valid = 1'b1;
   end

   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_reg               <= '0;
         s_reg.reload_value  <= `TSSC_RST_RELOAD;
         s_reg.reload_shadow <= `TSSC_RST_RELOAD;
      end else begin
         s_reg <= s_next;
      end
   end

   // outputs; reads answer in the data phase combinationally from state
   assign hreadyout       = 1'b1;
   assign hresp           = 1'b0;
   assign hrdata          = rd;
   assign trigger_irq     = s_reg.trigger_flag & s_reg.trigger_irq_enable;
   assign trigger_dma     = s_reg.trigger_flag & s_reg.trigger_dma_enable;
   assign update_irq      = s_reg.update_flag & s_reg.update_irq_enable;
   assign update_event    = upd_req;
   assign counter_running = s_reg.ctrl1.counter_run_bit;
   assign sample_tick     = s_reg.dts_tick;
   assign count_value     = s_reg.count;

endmodule // tssc_timer

// *** rtl/tssc_defines.svh ***
`ifndef TSSC_DEFINES_SVH
`define TSSC_DEFINES_SVH
// register byte offsets
`define TSSC_OFS_CTRL1   12'h000
`define TSSC_OFS_SLAVE   12'h008
`define TSSC_OFS_IRQEN   12'h00C
`define TSSC_OFS_STATUS  12'h010
`define TSSC_OFS_EVGEN   12'h014
`define TSSC_OFS_CHCFG   12'h020
`define TSSC_OFS_COUNT   12'h024
`define TSSC_OFS_PRESC   12'h028
`define TSSC_OFS_RELOAD  12'h02C
`define TSSC_OFS_CMP1    12'h034
`define TSSC_OFS_CMP2    12'h038
// control one fields
`define TSSC_CR1_RUN     0
`define TSSC_CR1_UPDINH  1
`define TSSC_CR1_UPDSRC  2
`define TSSC_CR1_SSHOT   3
`define TSSC_CR1_ARBUF   7
`define TSSC_CR1_CKD_LO  8
`define TSSC_CR1_MASK    16'h038F
// slave control fields
`define TSSC_SMS_LO      0
`define TSSC_TS_LO       4
`define TSSC_SLAVE_MASK  16'h0077
// enable register fields
`define TSSC_IE_UPD      0
`define TSSC_IE_TRG      6
`define TSSC_IE_TDMA     14
`define TSSC_IE_MASK     16'h4041
// status and event generation fields
`define TSSC_SR_UPD      0
`define TSSC_SR_TRG      6
`define TSSC_EG_UPD      0
`define TSSC_EG_TRG      6
// channel config fields: polarity bits 1 and 5
`define TSSC_CH_P1       1
`define TSSC_CH_P2       5
`define TSSC_CH_MASK     16'h0022
// reset values
`define TSSC_RST_16      16'h0000
`define TSSC_RST_RELOAD  16'hFFFF
`endif

// *** rtl/tssc_pkg.sv ***
package tssc_pkg;
   // slave mode codes
   typedef enum logic [2:0] {
      TSSC_SM_OFF   = 3'h0,
      TSSC_SM_ENC1  = 3'h1,
      TSSC_SM_ENC2  = 3'h2,
      TSSC_SM_ENC3  = 3'h3,
      TSSC_SM_RESET = 3'h4,
      TSSC_SM_GATED = 3'h5,
      TSSC_SM_TRIG  = 3'h6,
      TSSC_SM_EXTCK = 3'h7
   } tssc_sms_t;

   // control one register
   typedef struct packed {
      logic [1:0] sample_clock_divider;
      logic       reload_buffer_on;
      logic       single_shot_stop;
      logic       update_source_select;
      logic       update_inhibit;
      logic       counter_run_bit;
   } tssc_ctrl1_t;

   // whole state of the block
   typedef struct packed {
      tssc_ctrl1_t ctrl1;
      tssc_sms_t   slave_behaviour_select;
      logic [2:0]  trigger_source_select;
      logic        trigger_irq_enable;
      logic        trigger_dma_enable;
      logic        update_irq_enable;
      logic        trigger_flag;
      logic        update_flag;
      logic        chan1_polarity;
      logic        chan2_polarity;
      logic [15:0] count;
      logic [15:0] presc;
      logic [15:0] presc_cnt;
      logic [15:0] reload_value;
      logic [15:0] reload_shadow;
      logic [15:0] cmp1;
      logic [15:0] cmp2;
      logic [15:0] cmp1_shadow;
      logic [15:0] cmp2_shadow;
      logic [1:0]  sync1;
      logic [1:0]  sync2;
      logic [3:0]  itr_s1;
      logic [3:0]  itr_s2;
      logic        trig_prev;
      logic        gate_prev;
      logic [1:0]  dts_cnt;
      logic        dts_tick;
      logic [11:0] ph_addr;
      logic        ph_write;
      logic        ph_valid;
      logic [31:0] hrdata;
   } tssc_state_t;
endpackage

// *** tb/tssc_trig_pins.sv ***
`timescale 1ns/1ps
module tssc_trig_pins (
   // clock and commands from the bench
   input  wire logic       hclk,
   input  wire logic       slow,
   input  wire logic [1:0] want,
   // pins toward the timer
   output logic            timer_input_one,
   output logic            timer_input_two,
   output logic [3:0]      internal_trig
);
   logic [1:0] d1 = 2'h0;
   logic [1:0] d2 = 2'h0;
   logic [3:0] itr = 4'h0;
   // channel pins move only on command, after the timer clock already runs
   always @(posedge hclk) begin
      d1  <= want;
      d2  <= d1;
      itr <= itr + 4'h1; // unused triggers stay busy so a wrong select shows up
   end
   // a slow source lags its command by two cycles
   assign {timer_input_two, timer_input_one} = slow ? d2 : want;
   assign internal_trig = itr;
endmodule // tssc_trig_pins

// *** tb/tssc_timer_monitor.sv ***
`timescale 1ns/1ps
module tssc_timer_monitor (
   // bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic        hreadyout,
   input wire logic        hresp,
   input wire logic [31:0] hrdata,
   // timer side
   input wire logic        core_halted,
   input wire logic        debug_freeze_select,
   input wire logic        trigger_irq,
   input wire logic        update_event,
   input wire logic        counter_running,
   input wire logic [15:0] count_value
);
   logic rd_ph;
   // marks the data phase of a read
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn) rd_ph <= 1'b0;
      else rd_ph <= hsel && hready && htrans[1] && !hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   a_resp_okay: assert property (hresp == 1'b0)
      else $error("error response seen");
   a_ready_high: assert property (hreadyout == 1'b1)
      else $error("wait state seen");
   a_read_upper: assert property (rd_ph |-> hrdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_debug_hold: assert property ((core_halted && debug_freeze_select)[*2] |-> $stable(count_value))
      else $error("counter moved while frozen");
   a_count_step: assert property ($changed(count_value) |->
      count_value == $past(count_value) + 16'h0001 || count_value == 16'h0000)
      else $error("counter jumped");
   a_stopped_hold: assert property (!counter_running && !$past(counter_running) |->
      count_value == $past(count_value) || count_value == 16'h0000)
      else $error("counter ran with run bit clear");
   a_upd_single: assert property (update_event |=> !update_event)
      else $error("update longer than one cycle");
   a_upd_zero: assert property (update_event |=> count_value == 16'h0000)
      else $error("update did not restart counter");
   c_trig_irq: cover property ($rose(trigger_irq));
   c_update: cover property (update_event);
   c_freeze: cover property (core_halted && debug_freeze_select && counter_running);
endmodule // tssc_timer_monitor

// *** tb/tb_timer_slave_sync_control.sv ***
`timescale 1ns/1ps
`include "tssc_defines.svh"
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("CHECK FAILED at %0t got %h exp %h", $time, (a), (e)); end end
module tb_timer_slave_sync_control;
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0]  htrans = 2'h0, want = 2'h0;
   logic [2:0]  hsize = 3'h2;
   logic        hreadyout, hresp, core_halted = 1'b0, debug_freeze_select = 1'b0;
   logic        slow = 1'b0, timer_input_one, timer_input_two, trigger_irq, trigger_dma;
   logic        update_irq, update_event, counter_running, sample_tick;
   logic [3:0]  internal_trig;
   logic [15:0] count_value, c0;
   int          mismatches = 0, num_checks = 0, seed = 32'h6f41, n, saw;
   int          regm [int]; // expected register contents
   assign hready = hreadyout;
   always #5 hclk = ~hclk;
   tssc_timer i_dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
      .hready, .hreadyout, .hresp, .hrdata, .timer_input_one, .timer_input_two,
      .internal_trig, .core_halted, .debug_freeze_select, .trigger_irq, .trigger_dma,
      .update_irq, .update_event, .counter_running, .sample_tick, .count_value);
   tssc_trig_pins i_pins (.hclk, .slow, .want, .timer_input_one, .timer_input_two,
      .internal_trig);
   // verdict and end of run
   task give_verdict;
      if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // one bus phase; data sampled mid-cycle where it is settled
   task waitrdy;
      logic ok;
      n = 0;
      do begin
         @(negedge hclk);
         rd = hrdata;
         ok = hreadyout;
         @(posedge hclk);
         n++;
      end while (ok !== 1'b1 && n < 50);
      if (n >= 50) begin mismatches++; give_verdict; end
   endtask
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [2:0] s);
      @(posedge hclk);
      hsel <= 1'b1; haddr <= {20'h0, a}; htrans <= 2'h2; hwrite <= w; hsize <= s;
      waitrdy;
      htrans <= 2'h0; hwdata <= d;
      waitrdy;
   endtask
   task rdchk(input logic [11:0] a, input logic [15:0] e, input logic [2:0] s);
      xfer(1'b0, a, 32'h0, s);
      `CHK(rd[15:0], e)
   endtask
   // wait whole cycles, then step off the edge
   task cyc(input int k);
      repeat (k) @(posedge hclk);
      #1;
   endtask
   initial begin
      cyc(3);
      hresetn <= 1'b1;
      cyc(1);
      rdchk(`TSSC_OFS_CTRL1, `TSSC_RST_16, 3'h2);
      rdchk(`TSSC_OFS_RELOAD, `TSSC_RST_RELOAD, 3'h1);
      // random control word, then a byte write that must be ignored
      regm[0] = $random(seed) & 32'h038E;
      if (regm[0][9:8] == 2'h3) regm[0][9] = 1'b0; // divider code 11 is reserved
      xfer(1'b1, `TSSC_OFS_CTRL1, regm[0], 3'h1);
      xfer(1'b1, `TSSC_OFS_CTRL1, ~regm[0], 3'h0);
      rdchk(`TSSC_OFS_CTRL1, regm[0][15:0], 3'h0);
      // sampling ticks in sixteen cycles for each legal divider code
      for (int k = 0; k < 3; k++) begin
         xfer(1'b1, `TSSC_OFS_CTRL1, k << 8, 3'h2);
         cyc(4);
         saw = 0;
         repeat (16) begin cyc(1); saw += sample_tick; end
         `CHK(saw, 16 >> k)
      end
      // reset mode on channel one, plain then with updates inhibited
      xfer(1'b1, `TSSC_OFS_IRQEN, 32'h4041, 3'h1);
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h50, 3'h1);
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h54, 3'h1);
      for (int u = 0; u < 2; u++) begin
         xfer(1'b1, `TSSC_OFS_CHCFG, u << 1, 3'h1);
         xfer(1'b1, `TSSC_OFS_STATUS, 32'h0, 3'h1);
         xfer(1'b1, `TSSC_OFS_CTRL1, 1 | u << 1, 3'h1);
         cyc(20);
         want[0] <= ~want[0]; // rising first, falling under inverted polarity
         saw = 0;
         n = 0;
         do begin cyc(1); saw |= update_event; n++; end
         while (count_value > 16'h0005 && n < 20);
         `CHK(n < 20, 1'b1)
         `CHK(saw, 1 - u)
         `CHK({trigger_irq, trigger_dma}, 2'b11)
         `CHK(update_irq, 1 - u)
      end
      // gated mode on channel two through a slow source
      slow <= 1'b1;
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h60, 3'h1);
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h65, 3'h1);
      xfer(1'b1, `TSSC_OFS_CTRL1, 32'h0, 3'h1);
      want[1] <= 1'b1;
      cyc(8);
      c0 = count_value;
      cyc(10);
      `CHK(count_value, c0)
      xfer(1'b1, `TSSC_OFS_STATUS, 32'h0, 3'h1);
      xfer(1'b1, `TSSC_OFS_CTRL1, 32'h1, 3'h1);
      cyc(10);
      `CHK(count_value > c0, 1'b1)
      rdchk(`TSSC_OFS_STATUS, 16'h0040, 3'h2);
      xfer(1'b1, `TSSC_OFS_STATUS, 32'h0, 3'h1);
      want[1] <= 1'b0;
      cyc(8);
      c0 = count_value;
      cyc(10);
      `CHK(count_value, c0)
      rdchk(`TSSC_OFS_STATUS, 16'h0040, 3'h1);
      // trigger mode: hardware sets the run bit, counter is not cleared
      xfer(1'b1, `TSSC_OFS_CTRL1, 32'h0, 3'h1);
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h60, 3'h1);
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h66, 3'h1);
      `CHK(counter_running, 1'b0)
      want[1] <= 1'b1;
      n = 0;
      do begin cyc(1); n++; end while (counter_running !== 1'b1 && n < 20);
      `CHK(counter_running, 1'b1)
      `CHK(count_value >= c0, 1'b1)
      c0 = count_value;
      want[1] <= 1'b0;
      cyc(4);
      want[1] <= 1'b1;
      cyc(8);
      `CHK(count_value > c0 + 16'h0008, 1'b1)
      // debug halt: runs on unless the freeze select is set
      core_halted <= 1'b1;
      cyc(3);
      c0 = count_value;
      cyc(5);
      `CHK(count_value > c0, 1'b1)
      debug_freeze_select <= 1'b1;
      cyc(3);
      c0 = count_value;
      cyc(5);
      `CHK(count_value, c0)
      core_halted <= 1'b0;
      debug_freeze_select <= 1'b0;
      // external clock on channel two: each rise counts exactly once
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h60, 3'h1);
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h67, 3'h1);
      cyc(1);
      c0 = count_value;
      repeat (3) begin
         want[1] <= 1'b0;
         cyc(4);
         want[1] <= 1'b1;
         cyc(4);
      end
      cyc(6);
      `CHK(count_value, c0 + 16'h0003)
      // single shot with an unbuffered short reload
      xfer(1'b1, `TSSC_OFS_SLAVE, 32'h60, 3'h1);
      xfer(1'b1, `TSSC_OFS_RELOAD, 32'h20, 3'h2);
      xfer(1'b1, `TSSC_OFS_EVGEN, 32'h1, 3'h1);
      xfer(1'b1, `TSSC_OFS_CTRL1, 32'h9, 3'h1);
      n = 0;
      do begin cyc(1); n++; end while (counter_running !== 1'b0 && n < 60);
      `CHK(counter_running, 1'b0)
      `CHK(count_value, 16'h0000)
      give_verdict;
   end
endmodule // tb_timer_slave_sync_control
bind tssc_timer tssc_timer_monitor i_mon (.hclk, .hresetn, .hsel, .htrans, .hwrite, .hready,
   .hreadyout, .hresp, .hrdata, .core_halted, .debug_freeze_select, .trigger_irq,
   .update_event, .counter_running, .count_value);
